// ===== dv/cesc_pipe_model.sv
// Pipeline model that takes offered events after a set delay
`timescale 1ns/100ps
module cesc_pipe_model
   import cesc_pkg::*;
(
   input  wire logic          clock_in,
   input  wire logic          rstn_in,
   input  wire cesc_service_t service_in,
   input  wire logic          accept_en_in,
   input  wire logic [3:0]    delay_in,
   output logic               ack_out
);
   logic [3:0] wait_cnt;
   // One-cycle ack, only while an offer stands; delay models a busy core
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_out  <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (ack_out) begin
         ack_out  <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (service_in.valid && accept_en_in) begin
         ack_out  <= (wait_cnt == delay_in);
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         wait_cnt <= 4'h0;
      end
   end
endmodule : cesc_pipe_model

// ===== dv/testbench.sv
// Self-checking bench for the two-stage event controller
`timescale 1ns/100ps
module testbench
   import cesc_pkg::*;
;
   logic            clock_in, rstn_in, reg_wr, reg_rd, sup, idle, ack;
   logic            wake, acc_en;
   logic [2:0]      ctl;
   logic [3:0]      dly;
   logic [7:0]      addr;
   logic [31:0]     wdata, rdata, v;
   logic [NSRC-1:0] src;
   logic [6:0]      cev;
   logic [15:0]     pend;
   cesc_service_t   svc;
   int              errors, tests_run, cycles, n;

   cesc_top u_dut (
      .clock_in          (clock_in),
      .rstn_in           (rstn_in),
      .reg_addr_in       (addr),
      .reg_wdata_in      (wdata),
      .reg_wr_in         (reg_wr),
      .reg_rd_in         (reg_rd),
      .supervisor_in     (sup),
      .reg_rdata_out     (rdata),
      .src_irq_in        (src),
      .core_event_in     (cev),
      .global_int_on_in  (ctl[0]),
      .global_int_off_in (ctl[1]),
      .core_idle_in      (idle),
      .service_ack_in    (ack),
      .service_return_in (ctl[2]),
      .service_out       (svc),
      .core_pending_out  (pend),
      .wakeup_out        (wake)
   );

   cesc_pipe_model u_pipe (
      .clock_in     (clock_in),
      .rstn_in      (rstn_in),
      .service_in   (svc),
      .accept_en_in (acc_en),
      .delay_in     (dly),
      .ack_out      (ack)
   );

   task end_sim;
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      addr   <= a;
      wdata  <= d;
      reg_wr <= 1'b1;
      @(posedge clock_in);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_in);
      addr   <= a;
      reg_rd <= 1'b1;
      @(posedge clock_in);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // Bit 0 global on, bit 1 global off, bit 2 return
   task pulse(input logic [2:0] m);
      @(posedge clock_in);
      ctl <= m;
      @(posedge clock_in);
      ctl <= 3'h0;
   endtask : pulse

   task wait_pend(input logic [15:0] e);
      n = 0;
      while (pend !== e && n < 40) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      check({16'h0, pend}, {16'h0, e});
   endtask : wait_pend

   task t_regs;
      rd(ADDR_MASK, v); check(v, 32'h0);
      rd(ADDR_ASSIGN0 + 8'h08, v); check(v, 32'h2222_2211);
      rd(8'h30, v); check(v, 32'h0);
      wr(ADDR_MASK, 32'h0000_02c0);
      wr(ADDR_PENDING, 32'h0000_ffff);
      rd(ADDR_MASK, v); check(v, 32'h0000_02c0);
      rd(ADDR_PENDING, v); check(v, 32'h0);
      wr(ADDR_SMASK1, 32'hffff_ffff);
      rd(ADDR_SMASK1, v); check(v, 32'h0003_ffff);
   endtask : t_regs

   task t_latency;
      logic [3:0] lvl;
      wr(ADDR_SMASK0, 32'h0000_0001);
      pulse(3'h1);
      @(posedge clock_in);
      src[0] <= 1'b1;
      n = 0;
      lvl = 4'h0;
      while (pend[7] !== 1'b1 && n < 20) begin
         @(posedge clock_in);
         #1;
         n++;
         if (svc.valid === 1'b1) lvl = svc.level;
      end
      check({31'h0, n >= 4}, 32'h1);
      check({28'h0, lvl}, 32'h7);
      rd(ADDR_LATCHED, v); check(v, 32'h0);
      rd(ADDR_PENDING, v); check(v, 32'h80);
      @(posedge clock_in);
      src[0] <= 1'b0;
      @(posedge clock_in);
      src[0] <= 1'b1;
      repeat (2) @(posedge clock_in);
      rd(ADDR_LATCHED, v); check(v, 32'h80);
      check({31'h0, svc.valid}, 32'h0);
      pulse(3'h4);
      #1 check({16'h0, pend}, 32'h0);
      wait_pend(16'h0080);
      src[0] <= 1'b0;
      pulse(3'h4);
      wait_pend(16'h0000);
   endtask : t_latency

   task t_mask;
      wr(ADDR_SMASK0, 32'h0001_0000);
      @(posedge clock_in);
      src[16] <= 1'b1;
      repeat (4) @(posedge clock_in);
      rd(ADDR_LATCHED, v); check(v, 32'h100);
      check({31'h0, svc.valid}, 32'h0);
      @(posedge clock_in);
      sup <= 1'b0;
      wr(ADDR_LATCHED, 32'h0);
      rd(ADDR_LATCHED, v); check(v, 32'h0);
      sup <= 1'b1;
      rd(ADDR_LATCHED, v); check(v, 32'h100);
      wr(ADDR_LATCHED, 32'h0);
      rd(ADDR_LATCHED, v); check(v, 32'h0);
      src[16] <= 1'b0;
   endtask : t_mask

   task t_prio;
      dly <= 4'h3;
      wr(ADDR_SMASK0, 32'h0004_0000);
      pulse(3'h2);
      rd(ADDR_GLOBAL, v); check(v, 32'h0);
      @(posedge clock_in);
      src[18] <= 1'b1;
      repeat (10) @(posedge clock_in);
      #1 check({16'h0, pend}, 32'h0);
      pulse(3'h1);
      rd(ADDR_GLOBAL, v); check(v, 32'h1);
      wait_pend(16'h0200);
      cev[6] <= 1'b1;
      wait_pend(16'h0240);
      pulse(3'h4);
      wait_pend(16'h0200);
      pulse(3'h4);
      wait_pend(16'h0000);
      src[18] <= 1'b0;
      cev[6] <= 1'b0;
   endtask : t_prio

   // Source 0 moved to level 13, which stays masked so it only latches
   task t_route;
      wr(ADDR_ASSIGN0, 32'h0000_0006);
      wr(ADDR_SMASK0, 32'h0000_0001);
      @(posedge clock_in);
      src[0] <= 1'b1;
      repeat (4) @(posedge clock_in);
      rd(ADDR_LATCHED, v); check(v, 32'h2000);
      wr(ADDR_LATCHED, 32'h0);
      src[0] <= 1'b0;
      rd(ADDR_LATCHED, v); check(v, 32'h0);
   endtask : t_route

   task t_wake;
      wr(ADDR_WAKE0, 32'h2);
      @(posedge clock_in);
      idle   <= 1'b1;
      src[1] <= 1'b1;
      repeat (2) @(posedge clock_in);
      rd(ADDR_STATUS0, v); check(v, 32'h2);
      check({31'h0, wake}, 32'h1);
      rd(ADDR_LATCHED, v); check(v, 32'h0);
      idle <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1 check({31'h0, wake}, 32'h0);
      src[1] <= 1'b0;
   endtask : t_wake

   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end

   // A hang ends the run well after the sequence should be done
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim;
      end
   end

   initial begin
      rstn_in = 1'b0;
      {reg_wr, reg_rd, idle, ctl, dly, addr, wdata, src, cev} = '0;
      sup = 1'b1;
      acc_en = 1'b1;
      errors = 0;
      tests_run = 0;
      cycles = 0;
      repeat (6) @(posedge clock_in);
      rstn_in <= 1'b1;
      t_regs;
      t_latency;
      t_mask;
      t_prio;
      t_route;
      t_wake;
      end_sim;
   end
endmodule : testbench

// ===== hw/cesc_pkg.sv
// Constants, register map and carrier types of the event controller
package cesc_pkg;
   localparam int NLVL      = 16;
   localparam int NCORE     = 7;
   localparam int NGP       = 9;
   localparam int NSRC      = 50;
   localparam int NSRC_HI   = NSRC - 32;
   localparam int NASSIGN   = 7;
   localparam int GP_BASE   = 7;

   localparam logic [7:0] ADDR_LATCHED   = 8'h00;
   localparam logic [7:0] ADDR_MASK      = 8'h04;
   localparam logic [7:0] ADDR_PENDING   = 8'h08;
   localparam logic [7:0] ADDR_GLOBAL    = 8'h0c;
   localparam logic [7:0] ADDR_SMASK0    = 8'h10;
   localparam logic [7:0] ADDR_SMASK1    = 8'h14;
   localparam logic [7:0] ADDR_STATUS0   = 8'h18;
   localparam logic [7:0] ADDR_STATUS1   = 8'h1c;
   localparam logic [7:0] ADDR_WAKE0     = 8'h20;
   localparam logic [7:0] ADDR_WAKE1     = 8'h24;
   localparam logic [7:0] ADDR_ASSIGN0   = 8'h40;

   localparam logic [15:0] RST_LATCHED   = 16'h0000;
   localparam logic [15:0] RST_MASK      = 16'h0000;
   localparam logic [15:0] RST_PENDING   = 16'h0000;
   localparam logic        RST_GLOBAL_EN = 1'b0;
   localparam logic [NSRC-1:0] RST_SMASK = 50'h0;
   localparam logic [NSRC-1:0] RST_WAKE  = 50'h0;

   // Level code 0 selects general_level_7, 8 selects general_level_15
   localparam logic [NASSIGN*32-1:0] RST_ASSIGN =
      {24'h0, 200'h66666_5_44444444_3333333333_22222222_11_0000000000000000};

   localparam logic [4:0] LVL_NONE = 5'h10;

   typedef struct packed {
      logic       valid;
      logic [3:0] level;
   } cesc_service_t;
endpackage : cesc_pkg

// ===== hw/cesc_top.sv
// Two-stage event controller: system routing stage and core event stage
// Functional notes
// - Sixteen fixed priority levels, level 0 highest
// - Latched, mask, pending registers, sixteen bits each
// - Latched bit set on event, cleared on acceptance
// - Supervisor write cancels latched bit if masked
// - Set mask bit allows servicing; clear blocks it
// - Mask register supervisor read and write
// - Global enable and disable for general levels
// - Pending marks active or nested levels, read-only
// - System mask, status, wakeup sets per source
// - System mask bit gates its source
// - Status bit follows source request line
// - Wakeup enable lets source wake idle core
// - Default routing of sources to general levels
// - Pending bits serve as acknowledge to system
// - Rising edge latches, detection takes two cycles
// - Pending set clears latch, rearms edge capture
// - Shared level tolerates simultaneous source pulses
// - Edge to pending at least three cycles
// - Assignment registers reroute each source
// - Nested servicing, higher level preempts lower
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module cesc_top
   import cesc_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              rstn_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [31:0]       reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   input  wire logic              supervisor_in,
   output logic      [31:0]       reg_rdata_out,
   input  wire logic [NSRC-1:0]   src_irq_in,
   input  wire logic [NCORE-1:0]  core_event_in,
   input  wire logic              global_int_on_in,
   input  wire logic              global_int_off_in,
   input  wire logic              core_idle_in,
   input  wire logic              service_ack_in,
   input  wire logic              service_return_in,
   output cesc_service_t          service_out,
   output logic [NLVL-1:0]        core_pending_out,
   output logic                   wakeup_out
);

   logic [NLVL-1:0]        latched;
   logic [NLVL-1:0]        mask;
   logic                   global_en;
   logic [NSRC-1:0]        smask;
   logic [NSRC-1:0]        wake_en;
   logic [NSRC-1:0]        status;
   logic [NASSIGN*32-1:0]  assign_map;
   logic [NLVL-1:0]        ev_q;
   logic [NLVL-1:0]        ev_d;
   logic [NLVL-1:0]        rise;
   logic [NLVL-1:0]        sw_clr;
   logic [NLVL-1:0]        ack_hot;
   logic [NLVL-1:0]        ret_hot;
   logic [NLVL-1:0]        cand;
   logic [NGP-1:0]         gp_comb;
   logic [NGP-1:0]         src_lvl [NSRC];
   logic [4:0]             act_lvl;
   logic [4:0]             cand_lvl;
   logic [3:0]             svc_lvl;
   logic                   wr_ok;
   logic                   rd_ok;
   logic [31:0]            next_rdata;
   cesc_service_t          next_service;

   // Lowest set index wins, so level 0 outranks all others
   function automatic logic [4:0] first_set(input logic [NLVL-1:0] v);
      logic [4:0] r;
      r = LVL_NONE;
      for (int i = NLVL - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction : first_set

   assign wr_ok   = reg_wr_in && supervisor_in;
   assign rd_ok   = reg_rd_in && supervisor_in;
   assign svc_lvl = service_out.level;

   // System routing stage

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         smask <= RST_SMASK;
      end else if (wr_ok && reg_addr_in == ADDR_SMASK0) begin
         smask[31:0] <= reg_wdata_in;
      end else if (wr_ok && reg_addr_in == ADDR_SMASK1) begin
         smask[NSRC-1:32] <= reg_wdata_in[NSRC_HI-1:0];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wake_en <= RST_WAKE;
      end else if (wr_ok && reg_addr_in == ADDR_WAKE0) begin
         wake_en[31:0] <= reg_wdata_in;
      end else if (wr_ok && reg_addr_in == ADDR_WAKE1) begin
         wake_en[NSRC-1:32] <= reg_wdata_in[NSRC_HI-1:0];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         assign_map <= RST_ASSIGN;
      end else begin
         for (int j = 0; j < NASSIGN; j++) begin
            if (wr_ok && reg_addr_in == ADDR_ASSIGN0 + 8'(4 * j)) begin
               assign_map[j*32 +: 32] <= reg_wdata_in;
            end
         end
      end
   end

   // Status shows the raw request, unmasked, so shared levels can be
   // demultiplexed by software
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         status <= '0;
      end else begin
         status <= src_irq_in;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wakeup_out <= 1'b0;
      end else begin
         wakeup_out <= core_idle_in && |(src_irq_in & wake_en);
      end
   end

   generate
      for (genvar s = 0; s < NSRC; s++) begin : g_route
         logic [3:0] code;
         assign code = assign_map[s*4 +: 4];
         // Codes above 8 route nowhere
         assign src_lvl[s] = (src_irq_in[s] && smask[s]) ?
                             NGP'(9'h001 << code) : '0;
      end
   endgenerate

   always_comb begin
      gp_comb = '0;
      for (int s = 0; s < NSRC; s++) begin
         gp_comb = gp_comb | src_lvl[s];
      end
   end

   // Core event stage

   // Two flops give the two-cycle edge detection
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ev_q <= '0;
         ev_d <= '0;
      end else begin
         ev_q <= {gp_comb, core_event_in};
         ev_d <= ev_q;
      end
   end

   assign rise    = ev_q & ~ev_d;
   assign sw_clr  = (wr_ok && reg_addr_in == ADDR_LATCHED) ?
                    (~reg_wdata_in[NLVL-1:0] & ~mask) : '0;
   assign ack_hot = (service_ack_in && service_out.valid) ?
                    NLVL'(16'h0001 << svc_lvl) : '0;
   assign ret_hot = service_return_in ?
                    NLVL'(16'h0001 << act_lvl[3:0]) & core_pending_out :
                    '0;

   // A new edge in the clearing cycle is kept: set wins
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         latched <= RST_LATCHED;
      end else begin
         latched <= (latched & ~ack_hot & ~sw_clr) | rise;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask <= RST_MASK;
      end else if (wr_ok && reg_addr_in == ADDR_MASK) begin
         mask <= reg_wdata_in[NLVL-1:0];
      end
   end

   // Disable wins when both instructions retire in one cycle
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         global_en <= RST_GLOBAL_EN;
      end else if (global_int_off_in) begin
         global_en <= 1'b0;
      end else if (global_int_on_in) begin
         global_en <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         core_pending_out <= RST_PENDING;
      end else begin
         core_pending_out <= (core_pending_out | ack_hot) & ~ret_hot;
      end
   end

   assign act_lvl  = first_set(core_pending_out);
   assign cand     = latched & mask &
                     {{NGP{global_en}}, {NCORE{1'b1}}};
   assign cand_lvl = first_set(cand);

   // An ack in flight suppresses the next offer, else a stale level
   // could be offered twice
   always_comb begin
      next_service.valid = (cand_lvl < act_lvl) && !service_ack_in;
      next_service.level = cand_lvl[3:0];
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         service_out <= '0;
      end else begin
         service_out <= next_service;
      end
   end

   // Register read port

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_ok) begin
         case (reg_addr_in)
            ADDR_LATCHED: next_rdata = {16'h0000, latched};
            ADDR_MASK:    next_rdata = {16'h0000, mask};
            ADDR_PENDING: next_rdata = {16'h0000, core_pending_out};
            ADDR_GLOBAL:  next_rdata = {31'h0, global_en};
            ADDR_SMASK0:  next_rdata = smask[31:0];
            ADDR_SMASK1:  next_rdata = 32'(smask[NSRC-1:32]);
            ADDR_STATUS0: next_rdata = status[31:0];
            ADDR_STATUS1: next_rdata = 32'(status[NSRC-1:32]);
            ADDR_WAKE0:   next_rdata = wake_en[31:0];
            ADDR_WAKE1:   next_rdata = 32'(wake_en[NSRC-1:32]);
            default: begin
               for (int j = 0; j < NASSIGN; j++) begin
                  if (reg_addr_in == ADDR_ASSIGN0 + 8'(4 * j)) begin
                     next_rdata = assign_map[j*32 +: 32];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // Checks

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   edge_latches_a: assert property (
      (rise != 0) |=> ((latched & $past(rise)) == $past(rise)))
      else $error("edge not latched");

   ack_pends_a: assert property (
      (service_ack_in && service_out.valid) |=>
         core_pending_out[$past(svc_lvl)] && !latched[$past(svc_lvl)] ||
         core_pending_out[$past(svc_lvl)] && $past(rise[svc_lvl]))
      else $error("ack did not move event to pending");

   // The latch must have stood for two samples before the ack edge
   pend_latency_a: assert property (
      $rose(core_pending_out[GP_BASE]) |->
         $past(latched[GP_BASE], 1) && $past(service_out.valid, 1) &&
         $past(latched[GP_BASE], 2))
      else $error("pending set too early");

   // The offered level is the candidate of the previous cycle
   mask_blocks_a: assert property (
      service_out.valid |-> $past(mask[cand_lvl[3:0]]))
      else $error("masked event offered");

   global_off_a: assert property (
      !global_en |=> !(service_out.valid && service_out.level >= 4'h7))
      else $error("general level offered while disabled");

   outranks_act_a: assert property (
      service_out.valid |-> ({1'b0, svc_lvl} < act_lvl))
      else $error("offered level does not outrank active");

   status_follows_a: assert property (
      ##1 (status == $past(src_irq_in)))
      else $error("status does not follow source");

   wake_follows_a: assert property (
      ##1 (wakeup_out == $past(core_idle_in && |(src_irq_in & wake_en))))
      else $error("wakeup wrong");

   sw_cancel_a: assert property (
      (sw_clr != 0) |=> ((latched & $past(sw_clr) & ~$past(rise)) == 0))
      else $error("latched cancel failed");

   sw_keep_a: assert property (
      (wr_ok && reg_addr_in == ADDR_LATCHED) |=>
         ((latched & $past(latched & mask & ~ack_hot)) ==
          $past(latched & mask & ~ack_hot)))
      else $error("unmasked latched bit cancelled");

   rdata_idle_a: assert property (
      !rd_ok |=> (reg_rdata_out == 32'h0000_0000))
      else $error("read data not idle");

   pend_readonly_a: assert property (
      (wr_ok && reg_addr_in == ADDR_PENDING && ack_hot == '0 &&
       ret_hot == '0) |=> $stable(core_pending_out))
      else $error("pending register written");

   smask_write_a: assert property (
      (wr_ok && reg_addr_in == ADDR_SMASK0) |=>
         (smask[31:0] == $past(reg_wdata_in)))
      else $error("system mask write lost");

   mask_write_a: assert property (
      (wr_ok && reg_addr_in == ADDR_MASK) |=>
         (mask == $past(reg_wdata_in[NLVL-1:0])))
      else $error("event mask write lost");

   route_or_a: assert property (
      ##1 (ev_q[NLVL-1:GP_BASE] == $past(gp_comb)))
      else $error("general input not the routed OR");

   global_dis_a: assert property (
      global_int_off_in |=> !global_en)
      else $error("global disable ignored");

   global_en_a: assert property (
      (global_int_on_in && !global_int_off_in) |=> global_en)
      else $error("global enable ignored");

   // Return drops only the highest active level; nesting stays
   ret_clears_a: assert property (
      (service_return_in && act_lvl != LVL_NONE) |=>
         !core_pending_out[$past(act_lvl[3:0])])
      else $error("return did not clear active level");

   ack_drops_a: assert property (
      (service_ack_in && service_out.valid) |=> !service_out.valid)
      else $error("offer stands after ack");

   idle_wake_a: assert property (
      !core_idle_in |=> !wakeup_out)
      else $error("wakeup while core busy");

   nested_c: cover property (
      core_pending_out[GP_BASE] && core_pending_out[GP_BASE + 4]);
   ack_c: cover property (
      service_out.valid && service_ack_in ##1 core_pending_out != 0);
   wake_c: cover property (core_idle_in ##1 wakeup_out);
   requeue_c: cover property (
      (service_ack_in && service_out.valid) && rise[svc_lvl]);

endmodule : cesc_top
